// *** common/clk_cond_pkg.sv ***
// Behaviour
// (R01) Two-bit path select: 0 bypass, 1 divided, 2 delayed, 3 divided and delayed.
// (R02) Model latency over bypass: 100 ps divided, 400 ps delayed, 500 ps both, plus delay.
// (R03) Divide code only acts in the two dividing path modes.
// (R04) Output ratio is twice the eight-bit divide code; zero invalid, default 1.
// (R05) Host pulses the active-low sync pin after writing all divide codes.
// (R06) Delay code only acts in the two delaying path modes.
// (R07) Added delay is delay code times 150 ps, 0 to 2250 ps, default 0.
// (R08) Output on only with own enable, global enable bit and global pin high.
// (R09) Global enable bit at 0 turns every output off; default 1.
// (R10) Lock-detect prescale bit divides lock detector rate by 4; host sets above 20 MHz.
// (R11) Reference divider divides by its twelve-bit value; zero invalid, default 10.
// (R12) Four-bit lock pin select picks high-impedance, levels, lock detect or divider halves.
// (R13) Sleep bit at 1 powers down everything regardless of other bits; default 0.
// (R14) Pump float bit at 1 places charge pump in high impedance.
// (R15) Pump polarity bit: 0 negative (default), 1 positive.
// (R16) Feedback divider divides by its eighteen-bit value; default 760, zero illegal.
// (R17) Reset bit 31 of channel 0 write restores all power-on values, ignores the rest.
// (R18) Pump gain code selects 1x, 4x, 16x or 32x current.
// (R19) Host never writes invalid codes; behaviour for them is undefined.
package clk_cond_pkg;
  // ----------------------------------------
  // Serial frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 3;
  localparam logic [3:0] ADDR_CH_LAST = 4'h7;
  localparam logic [3:0] ADDR_LOCK_CFG = 4'hB;
  localparam logic [3:0] ADDR_REF_GLOBAL = 4'hE;
  localparam logic [3:0] ADDR_FB_DIV = 4'hF;
  // ----------------------------------------
  // Channel register fields
  // ----------------------------------------
  localparam int RESET_POS = 31;
  localparam int PATH_LSB = 17;
  localparam int PATH_MSB = 18;
  localparam int EN_POS = 16;
  localparam int DIV_LSB = 8;
  localparam int DIV_MSB = 15;
  localparam int DLY_LSB = 4;
  localparam int DLY_MSB = 7;
  // ----------------------------------------
  // PLL register fields
  // ----------------------------------------
  localparam int PRESCALE_POS = 15;
  localparam int ALL_EN_POS = 27;
  localparam int SLEEP_POS = 26;
  localparam int FLOAT_POS = 25;
  localparam int POL_POS = 24;
  localparam int LOCKSEL_LSB = 20;
  localparam int LOCKSEL_MSB = 23;
  localparam int RDIV_LSB = 8;
  localparam int RDIV_MSB = 19;
  localparam int GAIN_LSB = 30;
  localparam int GAIN_MSB = 31;
  localparam int NDIV_LSB = 8;
  localparam int NDIV_MSB = 25;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [1:0] PATH_RST = 2'h0;
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [3:0] DLY_RST = 4'h0;
  localparam logic EN_RST = 1'b0;
  localparam logic ALL_EN_RST = 1'b1;
  localparam logic [11:0] RDIV_RST = 12'h00A;
  localparam logic [17:0] NDIV_RST = 18'h002F8;
  localparam logic [3:0] LOCKSEL_RST = 4'h0;
  localparam logic [1:0] GAIN_RST = 2'h0;
  // ----------------------------------------
  // Path modes and model latency in ps
  // ----------------------------------------
  localparam logic [1:0] PATH_BYPASS = 2'h0;
  localparam logic [1:0] PATH_DIV = 2'h1;
  localparam logic [1:0] PATH_DLY = 2'h2;
  localparam logic [1:0] PATH_BOTH = 2'h3;
  localparam logic [11:0] LAT_DIV_PS = 12'h064;
  localparam logic [11:0] LAT_DLY_PS = 12'h190;
  localparam logic [11:0] LAT_BOTH_PS = 12'h1F4;
  localparam logic [11:0] DLY_STEP_PS = 12'h096;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
endpackage

// *** design/out_channel.sv ***
`timescale 1ns/1ps
module out_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic align,
  input wire logic allow,
  input wire logic [1:0] path_select,
  input wire logic [7:0] divide_code,
  input wire logic [3:0] delay_code,
  // Outputs
  output logic clk_out,
  output logic out_on,
  output logic [11:0] latency_ps
);
  logic [7:0] count_reg;
  logic divides;
  logic delays;

  // ----------------------------------------
  // Path decode
  // ----------------------------------------
  assign divides = path_select[0]; // R01 R03
  assign delays = path_select[1]; // R01 R06

  // ----------------------------------------
  // Divider; held cleared while aligning so all channels restart together
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !run || align) begin
      count_reg <= 8'h00;
      clk_out <= 1'b0;
    end else if (!divides) begin
      count_reg <= 8'h00;
      clk_out <= !clk_out;
    end else if (count_reg >= divide_code - 8'h01) begin // R04
      count_reg <= 8'h00;
      clk_out <= !clk_out;
    end else begin
      count_reg <= count_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_on <= 1'b0;
    end else begin
      out_on <= allow && run; // R08
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latency_ps <= 12'h000;
    end else if (!delays) begin
      latency_ps <= divides ? clk_cond_pkg::LAT_DIV_PS : 12'h000; // R02 R06
    end else begin
      latency_ps <= (divides ? clk_cond_pkg::LAT_BOTH_PS : clk_cond_pkg::LAT_DLY_PS)
        + {8'h00, delay_code} * clk_cond_pkg::DLY_STEP_PS; // R02 R07
    end
  end

  bypass_lat_a: assert property (@(posedge clk) disable iff (rst) // R01
    path_select == clk_cond_pkg::PATH_BYPASS |=> latency_ps == 12'h000)
    else $error("bypass path shows latency");
  div_lat_a: assert property (@(posedge clk) disable iff (rst) // R06
    path_select == clk_cond_pkg::PATH_DIV |=> latency_ps == 12'h064)
    else $error("divided path latency wrong");
  both_lat_a: assert property (@(posedge clk) disable iff (rst) // R07
    path_select == clk_cond_pkg::PATH_BOTH && $stable(delay_code)
    |=> latency_ps == 12'h1F4 + 12'($past(delay_code)) * 12'h096)
    else $error("combined path latency wrong");
  div_ratio_a: assert property (@(posedge clk) disable iff (rst) // R04
    run && !align && divides && divide_code == 8'h05 && $changed(clk_out)
    ##1 (run && !align && divides && divide_code == 8'h05)[*4]
    |=> $changed(clk_out) && $past(clk_out, 5) == $past(clk_out))
    else $error("divider toggles off its ratio");
  bypass_cv: cover property (@(posedge clk) path_select == clk_cond_pkg::PATH_BYPASS && out_on);
endmodule

// *** design/clk_cond_cfg.sv ***
`timescale 1ns/1ps
module clk_cond_cfg #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial configuration pins
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  // Device pins
  input wire logic global_output_pin,
  input wire logic sync_n,
  input wire logic lock_sense,
  input wire logic analog_lock,
  // Clock outputs
  output logic [CHANNELS-1:0] clk_out,
  output logic [CHANNELS-1:0] out_on,
  output logic [CHANNELS-1:0][11:0] latency_ps,
  // Lock pin
  output logic lock_pin_out,
  output logic lock_pin_oe,
  // Charge pump and PLL state
  output logic pump_float,
  output logic pump_polarity,
  output logic [5:0] pump_gain_x,
  output logic asleep,
  output logic ref_half,
  output logic fb_half,
  output logic lock_detect
);
  generate
    if (CHANNELS < 1 || CHANNELS > 8) begin : bad_channels
      $error("CHANNELS must be 1 to 8");
    end
  endgenerate

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [6:0] pin_meta_reg;
  logic [6:0] pin_sync_reg;
  logic ser_clk_prev_reg;
  logic ser_latch_prev_reg;
  logic shift_edge;
  logic latch_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_reg <= 7'h00;
      pin_sync_reg <= 7'h00;
    end else begin
      pin_meta_reg <= {analog_lock, lock_sense, sync_n, global_output_pin,
                       ser_latch, ser_data, ser_clk};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ser_clk_prev_reg <= 1'b0;
      ser_latch_prev_reg <= 1'b0;
    end else begin
      ser_clk_prev_reg <= pin_sync_reg[0];
      ser_latch_prev_reg <= pin_sync_reg[2];
    end
  end

  assign shift_edge = pin_sync_reg[0] && !ser_clk_prev_reg;
  assign latch_edge = pin_sync_reg[2] && !ser_latch_prev_reg;

  // ----------------------------------------
  // Serial shift register, most significant bit first
  // ----------------------------------------
  logic [31:0] shift_reg;
  logic [3:0] addr;
  logic reset_write;

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= 32'h0000_0000;
    end else if (shift_edge) begin
      shift_reg <= {shift_reg[30:0], pin_sync_reg[1]};
    end
  end

  assign addr = shift_reg[clk_cond_pkg::ADDR_MSB:clk_cond_pkg::ADDR_LSB];
  assign reset_write = latch_edge && addr == 4'h0
    && shift_reg[clk_cond_pkg::RESET_POS]; // R17

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0][1:0] path_reg;
  logic [7:0][7:0] div_reg;
  logic [7:0][3:0] dly_reg;
  logic [7:0] en_reg;
  logic prescale_reg;
  logic all_en_reg;
  logic sleep_reg;
  logic float_reg;
  logic pol_reg;
  logic [3:0] locksel_reg;
  logic [11:0] rdiv_reg;
  logic [17:0] ndiv_reg;
  logic [1:0] gain_reg;

  // Write-only map: nothing reads back, so a reset write is the only recovery
  always_ff @(posedge clk) begin
    if (rst || reset_write) begin // R17
      for (int i = 0; i < 8; i++) begin
        path_reg[i] <= clk_cond_pkg::PATH_RST;
        div_reg[i] <= clk_cond_pkg::DIV_RST;
        dly_reg[i] <= clk_cond_pkg::DLY_RST;
        en_reg[i] <= clk_cond_pkg::EN_RST;
      end
    end else if (latch_edge && addr <= clk_cond_pkg::ADDR_CH_LAST) begin
      path_reg[addr[2:0]] <= shift_reg[clk_cond_pkg::PATH_MSB:clk_cond_pkg::PATH_LSB];
      div_reg[addr[2:0]] <= shift_reg[clk_cond_pkg::DIV_MSB:clk_cond_pkg::DIV_LSB];
      dly_reg[addr[2:0]] <= shift_reg[clk_cond_pkg::DLY_MSB:clk_cond_pkg::DLY_LSB];
      en_reg[addr[2:0]] <= shift_reg[clk_cond_pkg::EN_POS];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || reset_write) begin // R17
      prescale_reg <= 1'b0;
      all_en_reg <= clk_cond_pkg::ALL_EN_RST;
      sleep_reg <= 1'b0;
      float_reg <= 1'b0;
      pol_reg <= 1'b0;
      locksel_reg <= clk_cond_pkg::LOCKSEL_RST;
      rdiv_reg <= clk_cond_pkg::RDIV_RST;
      ndiv_reg <= clk_cond_pkg::NDIV_RST;
      gain_reg <= clk_cond_pkg::GAIN_RST;
    end else if (latch_edge && addr == clk_cond_pkg::ADDR_LOCK_CFG) begin
      prescale_reg <= shift_reg[clk_cond_pkg::PRESCALE_POS];
    end else if (latch_edge && addr == clk_cond_pkg::ADDR_REF_GLOBAL) begin
      all_en_reg <= shift_reg[clk_cond_pkg::ALL_EN_POS];
      sleep_reg <= shift_reg[clk_cond_pkg::SLEEP_POS];
      float_reg <= shift_reg[clk_cond_pkg::FLOAT_POS];
      pol_reg <= shift_reg[clk_cond_pkg::POL_POS];
      locksel_reg <= shift_reg[clk_cond_pkg::LOCKSEL_MSB:clk_cond_pkg::LOCKSEL_LSB];
      rdiv_reg <= shift_reg[clk_cond_pkg::RDIV_MSB:clk_cond_pkg::RDIV_LSB];
    end else if (latch_edge && addr == clk_cond_pkg::ADDR_FB_DIV) begin
      ndiv_reg <= shift_reg[clk_cond_pkg::NDIV_MSB:clk_cond_pkg::NDIV_LSB];
      gain_reg <= shift_reg[clk_cond_pkg::GAIN_MSB:clk_cond_pkg::GAIN_LSB];
    end
  end

  // ----------------------------------------
  // Output channels
  // ----------------------------------------
  logic outputs_allowed;
  logic align;

  assign outputs_allowed = all_en_reg && pin_sync_reg[3]; // R08 R09
  assign align = !pin_sync_reg[4]; // R05

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : chan
      out_channel u_ch (
        .clk(clk),
        .rst(rst),
        .run(!sleep_reg), // R13
        .align(align),
        .allow(outputs_allowed && en_reg[c]), // R08
        .path_select(path_reg[c]),
        .divide_code(div_reg[c]),
        .delay_code(dly_reg[c]),
        .clk_out(clk_out[c]),
        .out_on(out_on[c]),
        .latency_ps(latency_ps[c])
      );
    end
  endgenerate

  // ----------------------------------------
  // Reference and feedback dividers
  // ----------------------------------------
  logic [11:0] rcount_reg;
  logic [17:0] ncount_reg;
  logic r_tc;
  logic n_tc;

  assign r_tc = rcount_reg >= rdiv_reg - 12'h001; // R11
  assign n_tc = ncount_reg >= ndiv_reg - 18'h00001; // R16

  always_ff @(posedge clk) begin
    if (rst || sleep_reg) begin
      rcount_reg <= 12'h000;
      ref_half <= 1'b0;
    end else if (r_tc) begin
      rcount_reg <= 12'h000;
      ref_half <= !ref_half; // R11
    end else begin
      rcount_reg <= rcount_reg + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sleep_reg) begin
      ncount_reg <= 18'h00000;
      fb_half <= 1'b0;
    end else if (n_tc) begin
      ncount_reg <= 18'h00000;
      fb_half <= !fb_half; // R16
    end else begin
      ncount_reg <= ncount_reg + 18'h00001;
    end
  end

  // ----------------------------------------
  // Digital lock detect, sampled per phase-detector cycle, or every fourth one with the prescale bit set
  // ----------------------------------------
  logic [1:0] pre_reg;
  logic ld_tick;

  assign ld_tick = !sleep_reg && r_tc
    && (!prescale_reg || pre_reg == clk_cond_pkg::PRESCALE_LAST); // R10

  always_ff @(posedge clk) begin
    if (rst || sleep_reg) begin
      pre_reg <= 2'h0;
    end else if (r_tc) begin
      pre_reg <= pre_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sleep_reg) begin
      lock_detect <= 1'b0;
    end else if (ld_tick) begin
      lock_detect <= pin_sync_reg[5];
    end
  end

  // ----------------------------------------
  // Lock pin function
  // ----------------------------------------
  logic lock_out_next;
  logic lock_oe_next;

  always_comb begin
    lock_out_next = 1'b0;
    lock_oe_next = 1'b1;
    case (locksel_reg) // R12
      4'h1: lock_out_next = 1'b1;
      4'h2: lock_out_next = 1'b0;
      4'h3: lock_out_next = lock_detect;
      4'h4: lock_out_next = !lock_detect;
      4'h5: lock_out_next = pin_sync_reg[6];
      4'h6: lock_oe_next = !pin_sync_reg[6];
      4'h7: begin
        lock_out_next = 1'b1;
        lock_oe_next = pin_sync_reg[6];
      end
      4'h9: lock_out_next = fb_half;
      4'hB: lock_out_next = ref_half;
      default: lock_oe_next = 1'b0;
    endcase
    if (sleep_reg) begin
      lock_oe_next = 1'b0; // R13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lock_pin_out <= 1'b0;
      lock_pin_oe <= 1'b0;
    end else begin
      lock_pin_out <= lock_out_next;
      lock_pin_oe <= lock_oe_next;
    end
  end

  // ----------------------------------------
  // Charge pump controls
  // ----------------------------------------
  function automatic logic [5:0] gain_mult(input logic [1:0] code);
    case (code) // R18
      2'h0: gain_mult = 6'h01;
      2'h1: gain_mult = 6'h04;
      2'h2: gain_mult = 6'h10;
      default: gain_mult = 6'h20;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      pump_float <= 1'b0;
      pump_polarity <= 1'b0;
      pump_gain_x <= 6'h01;
      asleep <= 1'b0;
    end else begin
      pump_float <= float_reg || sleep_reg; // R14 R13
      pump_polarity <= pol_reg; // R15
      pump_gain_x <= gain_mult(gain_reg); // R18
      asleep <= sleep_reg; // R13
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  glob_off_a: assert property (@(posedge clk) disable iff (rst) // R09
    !all_en_reg |=> out_on == '0)
    else $error("output on with global enable clear");
  pin_off_a: assert property (@(posedge clk) disable iff (rst) // R08
    !pin_sync_reg[3] |=> out_on == '0)
    else $error("output on with global pin low");
  sleep_all_a: assert property (@(posedge clk) disable iff (rst) // R13
    sleep_reg |=> !lock_pin_oe && pump_float && out_on == '0 && asleep)
    else $error("block active while asleep");
  reset_bit_a: assert property (@(posedge clk) disable iff (rst) // R17
    reset_write |=> all_en_reg && rdiv_reg == 12'h00A && ndiv_reg == 18'h002F8
    && en_reg == 8'h00 && !reset_write)
    else $error("reset write left settings");
  float_pump_a: assert property (@(posedge clk) disable iff (rst) // R14
    float_reg |=> pump_float)
    else $error("pump not floated");
  polarity_a: assert property (@(posedge clk) disable iff (rst) // R15
    ##1 pump_polarity == $past(pol_reg))
    else $error("pump polarity mismatch");
  gain_max_a: assert property (@(posedge clk) disable iff (rst) // R18
    gain_reg == 2'h3 |=> pump_gain_x == 6'h20)
    else $error("pump gain code 3 not 32x");
  rdiv_three_a: assert property (@(posedge clk) disable iff (rst) // R11
    !sleep_reg && r_tc && rdiv_reg == 12'h003 ##1 (!sleep_reg && rdiv_reg == 12'h003)[*3]
    |-> r_tc && !$past(r_tc))
    else $error("reference divide by three wrong");
  ndiv_five_a: assert property (@(posedge clk) disable iff (rst) // R16
    !sleep_reg && n_tc && ndiv_reg == 18'h00005
    ##1 (!sleep_reg && ndiv_reg == 18'h00005)[*5] |-> n_tc && !$past(n_tc))
    else $error("feedback divide by five wrong");
  prescale_a: assert property (@(posedge clk) disable iff (rst) // R10
    ld_tick && prescale_reg |-> pre_reg == 2'h3 && r_tc)
    else $error("lock detect not prescaled by four");
  lock_high_a: assert property (@(posedge clk) disable iff (rst) // R12
    locksel_reg == 4'h1 && !sleep_reg |=> lock_pin_out && lock_pin_oe)
    else $error("lock pin not driven high");
  lock_invalid_a: assert property (@(posedge clk) disable iff (rst) // R12
    locksel_reg == 4'h8 || locksel_reg == 4'hA || locksel_reg >= 4'hC |=> !lock_pin_oe)
    else $error("invalid lock select drives pin");

  reset_cv: cover property (@(posedge clk) reset_write);
  divided_cv: cover property (@(posedge clk) out_on[0] && path_reg[0] == 2'h3);
  lock_cv: cover property (@(posedge clk) lock_detect && prescale_reg);
endmodule

// *** tb/serial_host.sv ***
`timescale 1ns/1ps
module serial_host (
  // Clock
  input wire logic clk,
  // Serial configuration pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end
  // Each level held 4 clks, one more than the synchroniser needs
  task automatic put(input logic c, input logic d, input logic l);
    @(posedge clk);
    ser_clk <= c;
    ser_data <= d;
    ser_latch <= l;
    repeat (3) @(posedge clk);
  endtask
  // Callers pass only valid divide and select codes
  task automatic write(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      put(1'b0, w[i], 1'b0);
      put(1'b1, w[i], 1'b0);
    end
    // Data line idles at the inverse so a stale bit is never mistaken for a live one
    put(1'b0, ~w[0], 1'b1);
    put(1'b0, ~w[0], 1'b0);
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, rst, global_output_pin, sync_n, lock_sense, analog_lock;
  logic ser_clk, ser_data, ser_latch;
  logic [7:0] clk_out, out_on;
  logic [7:0][11:0] latency_ps;
  logic lock_pin_out, lock_pin_oe, pump_float, pump_polarity, asleep;
  logic ref_half, fb_half, lock_detect;
  logic [5:0] pump_gain_x;
  logic [3:0] probe;
  int fail_count, check_count;
  assign probe = {fb_half, ref_half, clk_out[1], clk_out[0]};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  serial_host host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));
  clk_cond_cfg #(.CHANNELS(8)) DUT (
    .clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch),
    .global_output_pin(global_output_pin), .sync_n(sync_n), .lock_sense(lock_sense),
    .analog_lock(analog_lock), .clk_out(clk_out), .out_on(out_on), .latency_ps(latency_ps),
    .lock_pin_out(lock_pin_out), .lock_pin_oe(lock_pin_oe), .pump_float(pump_float),
    .pump_polarity(pump_polarity), .pump_gain_x(pump_gain_x), .asleep(asleep),
    .ref_half(ref_half), .fb_half(fb_half), .lock_detect(lock_detect)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] w);
    host.write(w);
    settle(8);
  endtask
  function automatic logic [31:0] ch(input logic [3:0] a, input logic [1:0] p,
      input logic e, input logic [7:0] dv, input logic [3:0] dl);
    ch = {13'h0000, p, e, dv, dl, a};
  endfunction
  function automatic logic [31:0] pll(input logic all_en, input logic slp, input logic fl,
      input logic pol, input logic [3:0] sel, input logic [11:0] rdiv);
    pll = {4'h0, all_en, slp, fl, pol, sel, rdiv, 4'h0, 4'hE};
  endfunction
  // Spacing in clks between two successive changes of one probed output
  task automatic gap(input int sel, input logic [31:0] exp);
    logic old;
    int n;
    n = 0;
    old = probe[sel];
    while (probe[sel] === old && n < 600) begin
      settle(1);
      n++;
    end
    old = probe[sel];
    n = 0;
    while (probe[sel] === old && n < 600) begin
      settle(1);
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      conclude();
    end
    check(n, exp);
  endtask
  // Lock detect follows its input only on its ticks
  task automatic lock_gap(input logic [31:0] exp);
    int n;
    n = 0;
    lock_sense <= 1'b0;
    while (lock_detect !== 1'b0 && n < 600) begin
      settle(1);
      n++;
    end
    lock_sense <= 1'b1;
    n = (n >= 600) ? 600 : 0;
    while (lock_detect !== 1'b1 && n < 600) begin
      settle(1);
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      conclude();
    end
    check(n, exp);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  logic [1:0] mode_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [3:0] dly_tab [4] = '{4'h5, 4'h9, 4'hF, 4'h1};
  logic [31:0] lat_tab [4] = '{32'h0, 32'd100, 32'd2650, 32'd650};
  logic [3:0] sel_tab [5] = '{4'h1, 4'h2, 4'h5, 4'h3, 4'h4};
  logic out_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [5:0] gain_tab [4] = '{6'h01, 6'h04, 6'h10, 6'h20};
  initial begin
    rst = 1'b1;
    global_output_pin = 1'b1;
    sync_n = 1'b1;
    lock_sense = 1'b1;
    analog_lock = 1'b1;
    fail_count = 0;
    check_count = 0;
    settle(2);
    rst <= 1'b0;
    settle(4);
    check(out_on, 32'h0);
    check(pump_float, 32'h0);
    check(pump_polarity, 32'h0);
    check(pump_gain_x, 32'h1);
    check(asleep, 32'h0);
    check(lock_pin_oe, 32'h0);
    // Channel c gets path mode c; delay and divide codes must be ignored where unused
    for (int c = 0; c < 4; c++) begin
      wr(ch(c[3:0], mode_tab[c], 1'b1, 8'h07 - c[7:0] * 8'h02, dly_tab[c]));
      check(latency_ps[c], lat_tab[c]);
      check(out_on[c], 32'h1);
    end
    check(latency_ps[2], 32'd2650);
    check(latency_ps[1], 32'd100);
    // Align the dividers after all divide codes are in place
    sync_n <= 1'b0;
    settle(4);
    sync_n <= 1'b1;
    settle(4);
    gap(0, 32'h1);
    gap(1, 32'h5);
    global_output_pin <= 1'b0;
    settle(6);
    check(out_on, 32'h0);
    global_output_pin <= 1'b1;
    settle(6);
    check(out_on, 32'h0F);
    wr(pll(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 12'h00A));
    check(out_on, 32'h0);
    wr(pll(1'b1, 1'b0, 1'b1, 1'b1, 4'h0, 12'h003));
    check(out_on, 32'h0F);
    check(pump_float, 32'h1);
    check(pump_polarity, 32'h1);
    gap(2, 32'h3);
    for (int g = 0; g < 4; g++) begin
      wr({g[1:0], 4'h0, 18'h00005, 4'h0, 4'hF});
      check(pump_gain_x, gain_tab[g]);
    end
    gap(3, 32'h5);
    for (int i = 0; i < 5; i++) begin
      wr(pll(1'b1, 1'b0, 1'b0, 1'b0, sel_tab[i], 12'h00A));
      check(lock_pin_oe, 32'h1);
      check(lock_pin_out, {31'h0, out_tab[i]});
    end
    wr({4'h0, 4'h1, 24'h00800B});
    lock_gap(32'd40);
    wr(pll(1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 12'h00A));
    check(asleep, 32'h1);
    check(out_on, 32'h0);
    check(pump_float, 32'h1);
    check(clk_out, 32'h0);
    check(lock_pin_oe, 32'h0);
    wr(pll(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 12'h00A));
    // Reset frame carries otherwise live fields that must be ignored
    wr(32'h8007FFF0 | ch(4'h0, 2'h3, 1'b1, 8'h09, 4'h3));
    check(out_on, 32'h0);
    check(latency_ps[0], 32'h0);
    check(lock_pin_oe, 32'h0);
    check(asleep, 32'h0);
    wr(ch(4'h2, 2'h0, 1'b1, 8'h01, 4'h0));
    check(out_on, 32'h04);
    conclude();
  end
endmodule
